// ---- hw/hbridge_controller.sv ----
/*
 * Controller end: turns a motor command and a duty word into the two
 * direction inputs, modulating drive against brake or coast.
 * Assumes the shared system clock; fault line arrives from the device pin.
 */
`timescale 1ns/10ps
module hbridge_controller
   import hbridge_pkg::*;
(
   input wire logic CLK_SYS_I,        // System clock
   input wire logic RST_I,            // Synchronous reset
   hbridge_if.ctrl LINK,              // Direction inputs and fault line
   input hbridge_pkg::motor_cmd_t CMD_I, // Requested motor command
   input wire logic FAST_DECAY_I,     // Off phase coasts instead of brakes
   input wire logic [7:0] DUTY_I,     // Drive share of each period, of 255
   output logic FAULT_O               // Device reports protection
);
   import hbridge_pkg::*;

   // 200 MHz / 2000 gives 100 kHz, the fastest modulation allowed
   localparam logic [10:0] PERIOD = 11'h7cf;

   logic [10:0] phase;
   logic f1, f2;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         phase <= 11'h000;
      end else if (phase >= PERIOD) begin
         phase <= 11'h000;
      end else begin
         phase <= phase + 1'b1;
      end
   end

   logic on_phase;
   assign on_phase = (DUTY_I == 8'hff) || ({phase, 3'h0} < (14'(DUTY_I) * 14'h3e));

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         LINK.dir_input_a <= 1'b0;
         LINK.dir_input_b <= 1'b0;
      end else begin
         case (CMD_I)
            CMD_FORWARD: begin
               // Slow decay: input a held static, b modulated; fast decay: a modulated, b low
               LINK.dir_input_a <= on_phase | ~FAST_DECAY_I;
               LINK.dir_input_b <= ~on_phase & ~FAST_DECAY_I;
            end
            CMD_REVERSE: begin
               LINK.dir_input_a <= ~on_phase & ~FAST_DECAY_I;
               LINK.dir_input_b <= on_phase | ~FAST_DECAY_I;
            end
            CMD_BRAKE: begin
               LINK.dir_input_a <= 1'b1;
               LINK.dir_input_b <= 1'b1;
            end
            default: begin
               LINK.dir_input_a <= 1'b0;
               LINK.dir_input_b <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         f1 <= 1'b0;
         f2 <= 1'b0;
      end else begin
         f1 <= ~LINK.fault_flag_low;
         f2 <= f1;
      end
   end
   assign FAULT_O = f2;
endmodule

// ---- hw/hbridge_motor_control_logic.sv ----
/*
 * Control logic of an H-bridge brushed DC motor driver: mode decode, sleep,
 * current chopping, dead time and protection sequencing.
 * Assumes the analog detectors arrive asynchronously and the direction inputs
 * come from the controller over hbridge_if.
 */
`timescale 1ns/10ps
module hbridge_motor_control_logic
   import hbridge_pkg::*;
#(
   parameter int SLEEP_CYCLES = SLEEP_CYC,
   parameter int WAKE_CYCLES = WAKE_DELAY_CYC,
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   input wire logic CLK_SYS_I,        // System clock
   input wire logic RST_I,            // Synchronous reset, power-up
   hbridge_if.device LINK,            // Direction inputs and fault line
   input wire logic CHOP_TRIP_I,      // Sense comparator at trip current
   input wire logic SUPPLY_LOW_I,     // Undervoltage detector
   input wire logic OVERCURRENT_I,    // Overcurrent detector
   input wire logic OVERHEAT_I,       // Over-temperature detector
   output logic HS_A_O,               // High-side switch, output a
   output logic LS_A_O,               // Low-side switch, output a
   output logic HS_B_O,               // High-side switch, output b
   output logic LS_B_O,               // Low-side switch, output b
   output logic SLEEP_O               // Sleep state
);
   import hbridge_pkg::*;

   typedef enum {ST_SLEEP, ST_WAKE, ST_RUN} pwr_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [5:0] sync1;
   logic [5:0] sync2;
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end else begin
         sync1 <= {LINK.dir_input_a, LINK.dir_input_b, CHOP_TRIP_I, SUPPLY_LOW_I,
                   OVERCURRENT_I, OVERHEAT_I};
         sync2 <= sync1;
      end
   end
   logic in_a, in_b, trip, uv, oc_raw, ot;
   assign {in_a, in_b, trip, uv, oc_raw, ot} = sync2;

   ////////////////////////////////////////////////////////////////////////////////
   // Power state: sleep, wake, run
   pwr_t pwr;
   logic [CNT_W-1:0] pwr_cnt;
   logic any_high;
   assign any_high = in_a | in_b;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         pwr <= ST_SLEEP;
         pwr_cnt <= '0;
      end else begin
         case (pwr)
            ST_SLEEP: begin
               // A short glitch does not wake; the hold must be uninterrupted
               if (!any_high) begin
                  pwr_cnt <= '0;
               end else if (pwr_cnt >= CNT_W'(WAKE_HOLD_CYC - 1)) begin
                  pwr <= ST_WAKE;
                  pwr_cnt <= '0;
               end else begin
                  pwr_cnt <= pwr_cnt + 1'b1;
               end
            end
            ST_WAKE: begin
               if (pwr_cnt >= CNT_W'(WAKE_CYCLES - 1)) begin
                  pwr <= ST_RUN;
                  pwr_cnt <= '0;
               end else begin
                  pwr_cnt <= pwr_cnt + 1'b1;
               end
            end
            ST_RUN: begin
               if (any_high) begin
                  pwr_cnt <= '0;
               end else if (pwr_cnt >= CNT_W'(SLEEP_CYCLES - 1)) begin
                  pwr <= ST_SLEEP;
                  pwr_cnt <= '0;
               end else begin
                  pwr_cnt <= pwr_cnt + 1'b1;
               end
            end
            default: begin
               pwr <= ST_SLEEP;
               pwr_cnt <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overcurrent deglitch and retry
   logic [CNT_W-1:0] oc_cnt;
   logic oc_retry;
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         oc_retry <= 1'b0;
         oc_cnt <= '0;
      end else if (oc_retry) begin
         if (oc_cnt >= CNT_W'(RETRY_CYCLES - 1)) begin
            oc_retry <= 1'b0;
            oc_cnt <= '0;
         end else begin
            oc_cnt <= oc_cnt + 1'b1;
         end
      end else if (oc_raw) begin
         // Re-arms after each retry, so a lasting short repeats the cycle
         if (oc_cnt >= CNT_W'(DEGLITCH_CYC)) begin
            oc_retry <= 1'b1;
            oc_cnt <= '0;
         end else begin
            oc_cnt <= oc_cnt + 1'b1;
         end
      end else begin
         oc_cnt <= '0;
      end
   end

   logic protect;
   assign protect = uv | oc_retry | ot;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         LINK.fault_flag_low_oe <= 1'b0;
      end else begin
         LINK.fault_flag_low_oe <= protect;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Current chopping off-time
   logic chop;
   logic [CNT_W-1:0] chop_cnt;
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         chop <= 1'b0;
         chop_cnt <= '0;
      end else if (chop) begin
         if (chop_cnt >= CNT_W'(CHOP_CYC - 1)) begin
            chop <= 1'b0;
            chop_cnt <= '0;
         end else begin
            chop_cnt <= chop_cnt + 1'b1;
         end
      end else if (trip && pwr == ST_RUN && !protect && any_high) begin
         chop <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Target drive per half-bridge
   half_drive_t want_a, want_b;
   always_comb begin
      want_a = HALF_OFF;
      want_b = HALF_OFF;
      if (pwr == ST_RUN && !protect) begin
         if (chop) begin
            want_a = HALF_LOW;
            want_b = HALF_LOW;
         end else begin
            case ({in_a, in_b})
               2'b01: begin
                  want_a = HALF_LOW;
                  want_b = HALF_HIGH;
               end
               2'b10: begin
                  want_a = HALF_HIGH;
                  want_b = HALF_LOW;
               end
               2'b11: begin
                  want_a = HALF_LOW;
                  want_b = HALF_LOW;
               end
               default: begin
                  want_a = HALF_OFF;
                  want_b = HALF_OFF;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Dead-time insertion, one per half-bridge
   half_drive_t want [2];
   logic [1:0] hs, ls;
   assign want[0] = want_a;
   assign want[1] = want_b;

   for (genvar g = 0; g < 2; g++) begin : g_half
      half_drive_t cur;
      logic [7:0] dead_cnt;
      always_ff @(posedge CLK_SYS_I) begin
         if (RST_I) begin
            cur <= HALF_OFF;
            dead_cnt <= 8'h00;
         end else if (want[g] == HALF_OFF) begin
            // Disabling is immediate; protection must never wait
            cur <= HALF_OFF;
            dead_cnt <= 8'(DEAD_CYC);
         end else if (want[g] != cur) begin
            if (cur != HALF_OFF) begin
               cur <= HALF_OFF;
               dead_cnt <= 8'(DEAD_CYC - 1);
            end else if (dead_cnt != 8'h00) begin
               dead_cnt <= dead_cnt - 1'b1;
            end else begin
               cur <= want[g];
            end
         end
      end
      assign hs[g] = (cur == HALF_HIGH);
      assign ls[g] = (cur == HALF_LOW);
   end

   assign HS_A_O = hs[0];
   assign LS_A_O = ls[0];
   assign HS_B_O = hs[1];
   assign LS_B_O = ls[1];
   assign SLEEP_O = (pwr == ST_SLEEP);
endmodule

// ---- pkg/hbridge_if.sv ----
/*
 * Link between the controller end and the motor control logic.
 * Assumes both ends share CLK_SYS_I; the fault line is open drain, resolved here.
 */
`timescale 1ns/10ps
interface hbridge_if;
   logic dir_input_a;
   logic dir_input_b;
   logic fault_flag_low_oe;
   logic fault_flag_low;

   // Open-drain fault: low while the device drives, else pulled up
   assign fault_flag_low = ~fault_flag_low_oe;

   modport device (
      input dir_input_a,
      input dir_input_b,
      output fault_flag_low_oe
   );

   modport ctrl (
      output dir_input_a,
      output dir_input_b,
      input fault_flag_low
   );
endinterface

// ---- pkg/hbridge_pkg.sv ----
/*
 * Shared constants and types for the H-bridge motor control logic and its controller end.
 * Assumes a single 200 MHz system clock for both ends.
 */
package hbridge_pkg;

   localparam int CLK_MHZ = 200;

   // Times in their own units, cycle counts derived from the clock rate
   localparam int SLEEP_ENTRY_DELAY_US = 1000;
   localparam int WAKE_HOLD_NS = 5000;
   localparam int WAKE_DELAY_US = 50;
   localparam int CHOP_OFF_TIME_US = 25;
   localparam int DEAD_INTERVAL_NS = 220;
   localparam int OVERCURRENT_DEGLITCH_NS = 1500;
   localparam int OVERCURRENT_RETRY_INTERVAL_US = 3000;

   localparam int SLEEP_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
   localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
   localparam int CHOP_CYC = CHOP_OFF_TIME_US * CLK_MHZ;
   localparam int DEAD_CYC = (DEAD_INTERVAL_NS * CLK_MHZ + 999) / 1000;
   localparam int DEGLITCH_CYC = (OVERCURRENT_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int RETRY_CYC = OVERCURRENT_RETRY_INTERVAL_US * CLK_MHZ;

   localparam int CNT_W = 20;

   // Drive level of one half-bridge
   typedef enum logic [1:0] {
      HALF_OFF,
      HALF_LOW,
      HALF_HIGH
   } half_drive_t;

   // Motor commands of the controller end
   typedef enum logic [1:0] {
      CMD_COAST,
      CMD_REVERSE,
      CMD_FORWARD,
      CMD_BRAKE
   } motor_cmd_t;

endpackage

// ---- test/hbridge_asserts.sv ----
/*
 * Checker for the link between controller and motor logic, and the bridge switches.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/10ps
module hbridge_asserts (
   input wire logic CLK_SYS_I,         // System clock
   input wire logic RST_I,             // Synchronous reset
   input wire logic dir_input_a,       // Direction input a
   input wire logic dir_input_b,       // Direction input b
   input wire logic fault_flag_low_oe, // Device pulls fault low
   input wire logic HS_A_O,            // High side a
   input wire logic LS_A_O,            // Low side a
   input wire logic HS_B_O,            // High side b
   input wire logic LS_B_O,            // Low side b
   input wire logic SLEEP_O,           // Sleep state
   input wire logic SUPPLY_LOW_I,      // Undervoltage detector
   input wire logic OVERHEAT_I         // Over-temperature detector
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   logic any_on;
   assign any_on = HS_A_O | LS_A_O | HS_B_O | LS_B_O;
   ////////////////////////////////////////////////////////////////////////////////
   a_no_shoot_a: assert property (!(HS_A_O && LS_A_O))
      else $error("both switches of half a on");
   a_no_shoot_b: assert property (!(HS_B_O && LS_B_O))
      else $error("both switches of half b on");
   a_dead_gap_a: assert property ($fell(HS_A_O) |-> !LS_A_O [*8])
      else $error("low side a on too soon after high side");
   a_dead_gap_b: assert property ($fell(HS_B_O) |-> !LS_B_O [*8])
      else $error("low side b on too soon after high side");
   a_sleep_all_off: assert property (SLEEP_O |-> !any_on)
      else $error("switch on while asleep");
   a_fault_all_off: assert property (fault_flag_low_oe |-> !any_on)
      else $error("switch on during protection");
   a_sleep_stays: assert property (SLEEP_O && !dir_input_a && !dir_input_b |=> SLEEP_O)
      else $error("woke with both inputs low");
   a_wake_quiet: assert property ($fell(SLEEP_O) |-> !(HS_A_O || HS_B_O) [*8])
      else $error("high side on at once after sleep exit");
   a_supply_fault: assert property (SUPPLY_LOW_I [*6] |-> fault_flag_low_oe)
      else $error("no fault during undervoltage");
   a_heat_fault: assert property (OVERHEAT_I [*6] |-> fault_flag_low_oe)
      else $error("no fault during overheat");
   c_forward: cover property (HS_A_O && LS_B_O);
   c_brake: cover property (LS_A_O && LS_B_O);
   c_fault: cover property ($rose(fault_flag_low_oe));
   c_wake: cover property ($fell(SLEEP_O));
endmodule

// ---- test/tb_top.sv ----
/*
 * Bench joining controller end and motor logic through hbridge_if.
 * Assumes shortened sleep, wake and retry counts given by parameters.
 */
`timescale 1ns/10ps
module tb_top;
   import hbridge_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   motor_cmd_t cmd = CMD_COAST;
   logic fast = 1'b0;
   logic [7:0] duty = 8'hff;
   logic trip = 1'b0;
   logic uv = 1'b0;
   logic oc = 1'b0;
   logic hot = 1'b0;
   logic hs_a, ls_a, hs_b, ls_b, sleep, fault_out;
   logic [3:0] sw;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   assign sw = {hs_a, ls_a, hs_b, ls_b};
   always #2.5 clk_sys = ~clk_sys;
   hbridge_if link_if();
   hbridge_controller hbridge_controller_inst (.CLK_SYS_I(clk_sys), .RST_I(rst),
      .LINK(link_if), .CMD_I(cmd), .FAST_DECAY_I(fast), .DUTY_I(duty), .FAULT_O(fault_out));
   hbridge_motor_control_logic #(.SLEEP_CYCLES(200), .WAKE_CYCLES(50), .RETRY_CYCLES(600))
      hbridge_motor_control_logic_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .LINK(link_if),
      .CHOP_TRIP_I(trip), .SUPPLY_LOW_I(uv), .OVERCURRENT_I(oc), .OVERHEAT_I(hot),
      .HS_A_O(hs_a), .LS_A_O(ls_a), .HS_B_O(hs_b), .LS_B_O(ls_b), .SLEEP_O(sleep));
   hbridge_asserts hbridge_asserts_inst (.CLK_SYS_I(clk_sys), .RST_I(rst),
      .dir_input_a(link_if.dir_input_a), .dir_input_b(link_if.dir_input_b),
      .fault_flag_low_oe(link_if.fault_flag_low_oe), .HS_A_O(hs_a), .LS_A_O(ls_a),
      .HS_B_O(hs_b), .LS_B_O(ls_b), .SLEEP_O(sleep), .SUPPLY_LOW_I(uv), .OVERHEAT_I(hot));
   ////////////////////////////////////////////////////////////////////////////////
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task chk(input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task go(input motor_cmd_t c, input int n);
      cmd <= c;
      cyc(n);
   endtask
   // Bounded wait on the resolved fault pin, then judge its level
   task wait_pin(input logic v, input int n);
      int i;
      for (i = 0; i < n && link_if.fault_flag_low !== v; i++) cyc(1);
      chk({3'h0, link_if.fault_flag_low}, {3'h0, v});
   endtask
   task results();
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_sleep();
      chk({3'h0, sleep}, 4'h1);
      go(CMD_FORWARD, 500);
      go(CMD_COAST, 20);
      chk({3'h0, sleep}, 4'h1);
      go(CMD_FORWARD, 1300);
      chk({3'h0, sleep}, 4'h0);
      chk(sw, 4'b1001);
   endtask
   // Each row: command, duty, fast decay, expected switches
   task automatic t_modes();
      motor_cmd_t c[5] = '{CMD_REVERSE, CMD_BRAKE, CMD_FORWARD, CMD_FORWARD, CMD_COAST};
      logic [7:0] d[5] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff};
      logic f[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      logic [3:0] e[5] = '{4'b0110, 4'b0101, 4'b0101, 4'b0000, 4'b0000};
      for (int k = 0; k < 5; k++) begin
         duty <= d[k];
         fast <= f[k];
         go(c[k], 10);
         if (k == 0) chk(sw, 4'b0000);
         cyc(140);
         chk(sw, e[k]);
         // Back to full drive, else a coast row runs on into sleep
         duty <= 8'hff;
         fast <= 1'b0;
         go(CMD_FORWARD, 150);
      end
   endtask
   // One input static, the other toggling once per 2000-cycle period
   task t_pwm();
      int rises;
      int b_high;
      int a_low;
      logic b_prev;
      rises = 0;
      b_high = 0;
      a_low = 0;
      duty <= 8'h80;
      go(CMD_FORWARD, 10);
      b_prev = link_if.dir_input_b;
      repeat (4000) begin
         cyc(1);
         if (link_if.dir_input_b && !b_prev) rises++;
         if (link_if.dir_input_b) b_high++;
         if (!link_if.dir_input_a) a_low++;
         b_prev = link_if.dir_input_b;
      end
      chk({3'h0, a_low == 0}, 4'h1);
      chk({3'h0, rises == 2}, 4'h1);
      chk({3'h0, b_high > 1800 && b_high < 2200}, 4'h1);
      duty <= 8'hff;
   endtask
   task t_timer();
      go(CMD_COAST, 150);
      chk({3'h0, sleep}, 4'h0);
      go(CMD_FORWARD, 20);
      go(CMD_COAST, 150);
      chk({3'h0, sleep}, 4'h0);
      cyc(100);
      chk({3'h0, sleep}, 4'h1);
      chk(sw, 4'b0000);
   endtask
   task t_chop();
      go(CMD_FORWARD, 1300);
      trip <= 1'b1;
      cyc(4);
      trip <= 1'b0;
      cyc(100);
      chk(sw, 4'b0101);
      cyc(5000);
      chk(sw, 4'b1001);
   endtask
   task t_prot(input int which);
      if (which == 0) uv <= 1'b1;
      else hot <= 1'b1;
      cyc(20);
      chk(sw, 4'b0000);
      chk({3'h0, link_if.fault_flag_low}, 4'h0);
      chk({3'h0, fault_out}, 4'h1);
      uv <= 1'b0;
      hot <= 1'b0;
      cyc(100);
      chk({3'h0, link_if.fault_flag_low}, 4'h1);
      chk(sw, 4'b1001);
   endtask
   task t_oc();
      oc <= 1'b1;
      cyc(100);
      oc <= 1'b0;
      cyc(20);
      chk({3'h0, link_if.fault_flag_low}, 4'h1);
      oc <= 1'b1;
      cyc(330);
      chk(sw, 4'b0000);
      chk({3'h0, link_if.fault_flag_low}, 4'h0);
      wait_pin(1'b1, 700);
      wait_pin(1'b0, 400);
      oc <= 1'b0;
      wait_pin(1'b1, 700);
      cyc(100);
      chk(sw, 4'b1001);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_total++;
         results();
      end
   end
   initial begin
      cyc(3);
      rst <= 1'b0;
      cyc(5);
      t_sleep();
      t_modes();
      t_pwm();
      t_timer();
      t_chop();
      t_prot(0);
      t_prot(1);
      t_oc();
      results();
   end
endmodule
